// >>> src/secp_top.sv
`timescale 1ns/1ps
// Function
// - Low protect pin with protect-enable set blocks changes to protect bits.
// - Pause input low freezes the serial sequence; release resumes without restart.
// - Pause tied high never suspends the device.
// - Status register read-only when hardware protected or write latch clear.
// - Status bit 0 shows busy; while busy only status read is accepted.
// - Write latch clear refuses every status and array modification.
// - Write latch clears at power-up, sets only by set-latch instruction.
// - Status bits 2 and 3 are block-protect bits, factory value zero.
// - Block-protect code selects none, upper quarter, upper half or whole array.
// - Status bits 4 to 6 ignore writes and read zero when idle.
// - Protect-enable bit with low pin protects status register, never array.
// - Clearing protect-enable is refused while protect pin is low.
// - Status read during internal write returns all ones.
// - Select low, data sampled on rising clock, opcode first, MSB first.
// - Output bits change on falling serial clock edge.
// - Device returns to standby when the launched operation finishes.
// - Decode set-latch, clear-latch and status read opcodes, bit 3 ignored.
// - Decode status write, array read and array write with 16-bit address.
// - Decode page read and page/lock extended opcode with 16-bit address.
// - Address bit 10 selects page access (0) or lock access (1).
// - Clear-latch, status write and array write completion clear write latch.
module secp_top
   import secp_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES           // Self-timed write length in clk_sys cycles
)(
   input  wire logic        clk_sys,                // System clock
   input  wire logic        rst_n,                  // Reset, active low; synchronous in the clk_sys domain, asynchronous in the serial clock domain
   input  wire logic        spi_sck,                // Serial clock from master
   input  wire logic        cs_n,                   // Chip select, active low
   input  wire logic        si,                     // Serial data in
   input  wire logic        hold_n,                 // Pause input, active low
   input  wire logic        wp_n,                   // Write-protect pin, active low
   output logic             so,                     // Serial data out
   output logic             so_oe,                  // Serial out driven when high
   output logic [14:0]      rd_addr,                // Read address, serial clock domain
   output logic             rd_id,                  // Read targets the identification page
   input  wire logic [7:0]  rd_data,                // Read byte for rd_addr, serial clock domain
   output logic             mem_wr,                 // One-cycle write request, clk_sys
   output logic [14:0]      mem_addr,               // Write address
   output logic [7:0]       mem_data,               // Write byte
   output logic             mem_id,                 // Write targets the identification page
   output logic [7:0]       status,                 // Status byte as held
   output logic             hw_protect,             // Hardware protection active
   output logic             id_locked               // Identification page locked
);

   localparam int BCW = $clog2(WRITE_CYC + 1);

   if (WRITE_CYC < 1 || WRITE_CYC > 16777215) begin : g_bad_write_cyc
      $error("WRITE_CYC out of range");
   end

   typedef enum logic [0:0] {
      ST_STANDBY,
      ST_WRITING
   } secp_state_type;

   // ---------------- Serial clock domain ----------------

   logic              in_frame_q;
   logic              frame_tog_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [CNT_W-1:0]  cnt_eff;
   logic [7:0]        shift_q;
   logic [7:0]        shift_d;
   logic [7:0]        op_q;
   logic [15:0]       addr_q;
   logic [7:0]        data_q;
   logic [7:0]        stat_l1_q;
   logic [7:0]        stat_l2_q;
   logic              lock_l1_q;
   logic              lock_l2_q;
   logic [14:0]       rd_addr_q;
   logic              rd_id_q;
   logic              so_q;
   logic              so_oe_q;
   secp_cmd_type      cmd_l;
   logic              byte_end;
   logic              drive;
   logic [7:0]        out_byte;

   // A stale count from the last frame is never used: the first edge counts from zero
   assign cnt_eff  = in_frame_q ? cnt_q : '0;
   assign shift_d  = {shift_q[6:0], si};
   assign cmd_l    = secp_decode(op_q);
   assign byte_end = (cnt_eff[2:0] == 3'h7) && (cnt_eff >= CNT_ADH_LAST);
   assign cnt_d    = (cnt_eff == CNT_WRAP_TOP) ? CNT_DATA_DONE : cnt_eff + 6'h01;

   always_ff @(posedge spi_sck or posedge cs_n or negedge rst_n) begin
      if (!rst_n || cs_n) begin
         in_frame_q <= 1'b0;
      end else if (hold_n) begin
         in_frame_q <= 1'b1;
      end
   end

   // Marks a new frame for the system side; select alone cannot tell an empty frame
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         frame_tog_q <= 1'b0;
      end else if (!cs_n && hold_n && !in_frame_q) begin
         frame_tog_q <= ~frame_tog_q;
      end
   end

   // Held while paused; master keeps pause stable across edges
   always_ff @(posedge spi_sck) begin
      if (!cs_n && hold_n) begin
         shift_q <= shift_d;
         cnt_q   <= cnt_d;
         if (cnt_eff == CNT_OPC_LAST) begin
            op_q <= shift_d;
         end
         if (cnt_eff == CNT_ADH_LAST) begin
            addr_q[15:8] <= shift_d;
         end
         if (cnt_eff == CNT_ADL_LAST) begin
            addr_q[7:0] <= shift_d;
         end
         if (byte_end) begin
            data_q <= shift_d;
         end
      end
   end

   // Status is quasi-static across a frame; only the end of a write cycle moves it during one
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         stat_l1_q <= '0;
         stat_l2_q <= '0;
         lock_l1_q <= 1'b0;
         lock_l2_q <= 1'b0;
      end else begin
         stat_l1_q <= status;
         stat_l2_q <= stat_l1_q;
         lock_l1_q <= id_locked;
         lock_l2_q <= lock_l1_q;
      end
   end

   // Read pointer for array and page reads
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr_q <= '0;
         rd_id_q   <= 1'b0;
      end else if (!cs_n && hold_n) begin
         if (cnt_eff == CNT_ADL_LAST) begin
            rd_addr_q <= {addr_q[14:8], shift_d};
            rd_id_q   <= (cmd_l == CMD_ID_RD);
         end else if (byte_end && cnt_eff != CNT_ADH_LAST) begin
            if (rd_id_q) begin
               rd_addr_q[ID_PAGE_BITS-1:0] <= rd_addr_q[ID_PAGE_BITS-1:0] + 6'h01;
            end else begin
               rd_addr_q <= rd_addr_q + 15'h0001;
            end
         end
      end
   end

   always_comb begin
      drive    = 1'b0;
      out_byte = '0;
      unique case (cmd_l)
         CMD_STAT_RD: begin
            drive    = (cnt_eff >= CNT_OPC_DONE);
            out_byte = stat_l2_q[ST_BUSY_BIT] ? ST_BUSY_READ : stat_l2_q;
         end
         CMD_ARR_RD, CMD_ID_RD: begin
            drive    = (cnt_eff >= CNT_ADDR_DONE) && !stat_l2_q[ST_BUSY_BIT];
            out_byte = rd_data;
         end
         CMD_ID_EXT: begin
            drive    = (cnt_eff >= CNT_ADDR_DONE) && addr_q[ID_SEL_BIT] && !stat_l2_q[ST_BUSY_BIT];
            out_byte = {7'h00, lock_l2_q};
         end
         default: begin
            drive    = 1'b0;
            out_byte = '0;
         end
      endcase
      drive = drive && in_frame_q;
   end

   // Falling edge launches; select high releases at once
   always_ff @(negedge spi_sck or posedge cs_n or negedge rst_n) begin
      if (!rst_n || cs_n) begin
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (hold_n) begin
         so_oe_q <= drive;
         so_q    <= drive ? out_byte[3'h7 - cnt_eff[2:0]] : 1'b0;
      end
   end

   assign so      = so_q;
   assign so_oe   = so_oe_q;
   assign rd_addr = rd_addr_q;
   assign rd_id   = rd_id_q;

   // ---------------- System clock domain ----------------

   logic              cs_s1_q, cs_s2_q, cs_s3_q;
   logic              tog_s1_q, tog_s2_q, tog_seen_q;
   logic              wp_s1_q, wp_s2_q;
   logic              wel_q;
   logic [1:0]        bp_q;
   logic              hpe_q;
   logic              lock_q;
   logic              busy_q;
   logic [BCW-1:0]    busy_cnt_q;
   secp_state_type    state_q;
   secp_cmd_type      pend_cmd_q;
   logic [7:0]        pend_data_q;
   logic              mem_wr_q;
   logic [14:0]       mem_addr_q;
   logic [7:0]        mem_data_q;
   logic              mem_id_q;
   logic [7:0]        status_q;
   logic              hw_prot_q;
   logic              launch;
   secp_cmd_type      cmd_s;
   logic              hw_prot;
   logic              arr_prot;
   logic              clr_hpe_blocked;
   logic              go_set_wel;
   logic              go_clr_wel;
   logic              go_write;
   logic              write_done;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cs_s1_q  <= 1'b1;
         cs_s2_q  <= 1'b1;
         cs_s3_q  <= 1'b1;
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         wp_s1_q  <= 1'b1;
         wp_s2_q  <= 1'b1;
      end else begin
         cs_s1_q  <= cs_n;
         cs_s2_q  <= cs_s1_q;
         cs_s3_q  <= cs_s2_q;
         tog_s1_q <= frame_tog_q;
         tog_s2_q <= tog_s1_q;
         wp_s1_q  <= wp_n;
         wp_s2_q  <= wp_s1_q;
      end
   end

   // Frame registers are stable once select is high and the clock has stopped
   assign launch  = cs_s2_q && !cs_s3_q && (tog_s2_q != tog_seen_q);
   assign cmd_s   = secp_decode(op_q);
   assign hw_prot = hpe_q && !wp_s2_q;
   assign clr_hpe_blocked = hpe_q && !wp_s2_q && !data_q[ST_HPE_BIT];

   always_comb begin
      unique case (bp_q)
         2'h1:    arr_prot = (addr_q[14:0] >= PROT_BASE_QTR);
         2'h2:    arr_prot = (addr_q[14:0] >= PROT_BASE_HALF);
         2'h3:    arr_prot = (addr_q[14:0] >= PROT_BASE_ALL);
         default: arr_prot = 1'b0;
      endcase
   end

   // Only launched while idle; busy refuses everything but status read
   always_comb begin
      go_set_wel = 1'b0;
      go_clr_wel = 1'b0;
      go_write   = 1'b0;
      if (launch && !busy_q) begin
         unique case (cmd_s)
            CMD_SET_WL:  go_set_wel = (cnt_q == CNT_OPC_DONE);
            CMD_CLR_WL:  go_clr_wel = (cnt_q == CNT_OPC_DONE);
            CMD_STAT_WR: go_write = (cnt_q == CNT_STW_DONE) && wel_q && !hw_prot && !clr_hpe_blocked;
            CMD_ARR_WR:  go_write = (cnt_q == CNT_DATA_DONE) && wel_q && !arr_prot;
            CMD_ID_EXT:  go_write = (cnt_q == CNT_DATA_DONE) && wel_q && !lock_q &&
                                    (!addr_q[ID_SEL_BIT] || data_q[LOCK_DATA_BIT]);
            default:     go_write = 1'b0;
         endcase
      end
   end

   assign write_done = (state_q == ST_WRITING) && (busy_cnt_q == BCW'(1));

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tog_seen_q <= 1'b0;
      end else if (cs_s2_q && !cs_s3_q) begin
         tog_seen_q <= tog_s2_q;
      end
   end

   // Write cycle sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q     <= ST_STANDBY;
         busy_q      <= 1'b0;
         busy_cnt_q  <= '0;
         pend_cmd_q  <= CMD_NONE;
         pend_data_q <= '0;
      end else begin
         unique case (state_q)
            ST_STANDBY: begin
               if (go_write) begin
                  state_q     <= ST_WRITING;
                  busy_q      <= 1'b1;
                  busy_cnt_q  <= BCW'(WRITE_CYC);
                  pend_cmd_q  <= (cmd_s == CMD_ID_EXT && addr_q[ID_SEL_BIT]) ? CMD_NONE : cmd_s;
                  pend_data_q <= data_q;
               end
            end
            ST_WRITING: begin
               busy_cnt_q <= busy_cnt_q - BCW'(1);
               if (write_done) begin
                  state_q <= ST_STANDBY;
                  busy_q  <= 1'b0;
               end
            end
         endcase
      end
   end

   // Protect bits move only when the cycle ends; write latch also moves at set/clear-latch launch
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wel_q  <= WEL_RESET;
         bp_q   <= BP_RESET;
         hpe_q  <= HPE_RESET;
         lock_q <= LOCK_RESET;
      end else begin
         if (go_set_wel) begin
            wel_q <= 1'b1;
         end else if (go_clr_wel) begin
            wel_q <= 1'b0;
         end else if (write_done) begin
            wel_q <= 1'b0;
         end
         if (write_done && pend_cmd_q == CMD_STAT_WR) begin
            bp_q  <= {pend_data_q[ST_BP_HI_BIT], pend_data_q[ST_BP_LO_BIT]};
            hpe_q <= pend_data_q[ST_HPE_BIT];
         end
         if (write_done && pend_cmd_q == CMD_NONE) begin
            lock_q <= 1'b1;
         end
      end
   end

   // Array and page writes handed out at launch, single byte per frame
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mem_wr_q   <= 1'b0;
         mem_addr_q <= '0;
         mem_data_q <= '0;
         mem_id_q   <= 1'b0;
      end else begin
         mem_wr_q <= go_write && (cmd_s == CMD_ARR_WR ||
                     (cmd_s == CMD_ID_EXT && !addr_q[ID_SEL_BIT]));
         if (go_write) begin
            mem_addr_q <= addr_q[14:0];
            mem_data_q <= data_q;
            mem_id_q   <= (cmd_s == CMD_ID_EXT);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_q  <= '0;
         hw_prot_q <= 1'b0;
      end else begin
         status_q               <= '0;
         status_q[ST_BUSY_BIT]  <= busy_q;
         status_q[ST_WEL_BIT]   <= wel_q;
         status_q[ST_BP_LO_BIT] <= bp_q[0];
         status_q[ST_BP_HI_BIT] <= bp_q[1];
         status_q[ST_HPE_BIT]   <= hpe_q;
         hw_prot_q              <= hw_prot;
      end
   end

   assign mem_wr     = mem_wr_q;
   assign mem_addr   = mem_addr_q;
   assign mem_data   = mem_data_q;
   assign mem_id     = mem_id_q;
   assign status     = status_q;
   assign hw_protect = hw_prot_q;
   assign id_locked  = lock_q;

endmodule

// >>> src/secp_pkg.sv
package secp_pkg;

   // Instruction byte: bit 3 is don't-care, compare under mask
   localparam logic [7:0] OP_MASK         = 8'hF7;
   localparam logic [7:0] OP_SET_WL       = 8'h06;
   localparam logic [7:0] OP_CLR_WL       = 8'h04;
   localparam logic [7:0] OP_STAT_RD      = 8'h05;
   localparam logic [7:0] OP_STAT_WR      = 8'h01;
   localparam logic [7:0] OP_ARR_RD       = 8'h03;
   localparam logic [7:0] OP_ARR_WR       = 8'h02;
   localparam logic [7:0] OP_ID_RD        = 8'h83;
   localparam logic [7:0] OP_ID_EXT       = 8'h82;

   // Status byte fields
   localparam int         ST_BUSY_BIT     = 0;
   localparam int         ST_WEL_BIT      = 1;
   localparam int         ST_BP_LO_BIT    = 2;
   localparam int         ST_BP_HI_BIT    = 3;
   localparam int         ST_HPE_BIT      = 7;
   localparam logic [7:0] ST_BUSY_READ    = 8'hFF;
   localparam logic [1:0] BP_RESET        = 2'h0;
   localparam logic       HPE_RESET       = 1'b0;
   localparam logic       WEL_RESET       = 1'b0;
   localparam logic       LOCK_RESET      = 1'b0;

   // Block-protect lower bounds, upper bound is always 7FFFh
   localparam logic [14:0] PROT_BASE_QTR  = 15'h6000;
   localparam logic [14:0] PROT_BASE_HALF = 15'h4000;
   localparam logic [14:0] PROT_BASE_ALL  = 15'h0000;

   // Address bit that picks page access or lock access
   localparam int         ID_SEL_BIT      = 10;
   localparam int         LOCK_DATA_BIT   = 1;
   localparam int         ID_PAGE_BITS    = 6;

   // Serial bit counter landmarks
   localparam int         CNT_W           = 6;
   localparam logic [5:0] CNT_OPC_LAST    = 6'h07;
   localparam logic [5:0] CNT_OPC_DONE    = 6'h08;
   localparam logic [5:0] CNT_ADH_LAST    = 6'h0F;
   localparam logic [5:0] CNT_STW_DONE    = 6'h10;
   localparam logic [5:0] CNT_ADL_LAST    = 6'h17;
   localparam logic [5:0] CNT_ADDR_DONE   = 6'h18;
   localparam logic [5:0] CNT_DATA_DONE   = 6'h20;
   localparam logic [5:0] CNT_WRAP_TOP    = 6'h27;

   // Self-timed write cycle
   localparam int         CLK_PERIOD_NS   = 40;
   localparam int         T_WRITE_NS      = 5000000;
   localparam int         WRITE_CYCLES    = T_WRITE_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      CMD_NONE,
      CMD_SET_WL,
      CMD_CLR_WL,
      CMD_STAT_RD,
      CMD_STAT_WR,
      CMD_ARR_RD,
      CMD_ARR_WR,
      CMD_ID_RD,
      CMD_ID_EXT
   } secp_cmd_type;

   function automatic secp_cmd_type secp_decode(input logic [7:0] op);
      logic [7:0] m;
      m = op & OP_MASK;
      unique case (m)
         OP_SET_WL:  secp_decode = CMD_SET_WL;
         OP_CLR_WL:  secp_decode = CMD_CLR_WL;
         OP_STAT_RD: secp_decode = CMD_STAT_RD;
         OP_STAT_WR: secp_decode = CMD_STAT_WR;
         OP_ARR_RD:  secp_decode = CMD_ARR_RD;
         OP_ARR_WR:  secp_decode = CMD_ARR_WR;
         OP_ID_RD:   secp_decode = CMD_ID_RD;
         OP_ID_EXT:  secp_decode = CMD_ID_EXT;
         default:    secp_decode = CMD_NONE;
      endcase
   endfunction

endpackage

// >>> verification/secp_top_chk.sv
`timescale 1ns/1ps
module secp_top_chk
   import secp_pkg::*;
#(
   parameter int WRITE_CYC = 20 // Write cycle length
)(
   input wire logic        clk_sys,    // Clock
   input wire logic        rst_n,      // Reset
   input wire logic        wp_n,       // Protect pin
   input wire logic        mem_wr,     // Write pulse
   input wire logic [14:0] mem_addr,   // Write address
   input wire logic        mem_id,     // Page write
   input wire logic [7:0]  status,     // Status byte
   input wire logic        hw_protect  // Protect state
);
   int busy_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence write_done;
      $fell(status[ST_BUSY_BIT]);
   endsequence
   sequence pin_armed;
      (!wp_n && status[ST_HPE_BIT]) [*4];
   endsequence
   // Counter, since the write cycle is too long for a repetition
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busy_q <= 0;
      end else begin
         busy_q <= status[ST_BUSY_BIT] ? busy_q + 1 : 0;
      end
   end
   function automatic logic guarded(input logic [1:0] bp, input logic [14:0] a);
      return bp == 2'h3 || (bp == 2'h2 && a >= 15'h4000) || (bp == 2'h1 && a >= 15'h6000);
   endfunction
   wr_pulse_a: assert property (mem_wr |=> !mem_wr && status[ST_BUSY_BIT])
      else $error("write pulse not followed by busy");
   wr_latch_a: assert property (mem_wr |-> status[ST_WEL_BIT])
      else $error("write without latch");
   wr_unguarded_a: assert property (mem_wr && !mem_id |-> !guarded(status[3:2], mem_addr))
      else $error("write into protected block");
   busy_len_a: assert property (write_done |-> busy_q >= WRITE_CYC - 2 && busy_q <= WRITE_CYC + 1)
      else $error("write cycle length wrong");
   latch_drop_a: assert property (write_done |-> !status[ST_WEL_BIT])
      else $error("latch not cleared after write");
   hw_on_a: assert property (pin_armed |-> hw_protect)
      else $error("hardware protection missing");
   hw_off_a: assert property (wp_n [*4] |-> !hw_protect)
      else $error("hardware protection with pin high");
   bp_frozen_a: assert property (hw_protect |=> $stable({status[7], status[3:2]}))
      else $error("protect bits changed under protection");
   idle_zero_a: assert property (!status[ST_BUSY_BIT] |-> status[6:4] == 3'h0)
      else $error("unused status bits set");
endmodule
bind secp_top secp_top_chk #(.WRITE_CYC(WRITE_CYC)) i_secp_top_chk (.clk_sys, .rst_n, .wp_n, .mem_wr,
   .mem_addr, .mem_id, .status, .hw_protect);

// >>> verification/secp_master.sv
`timescale 1ns/1ps
module secp_master (
   output logic      spi_sck, // Serial clock
   output logic      cs_n,    // Select
   output logic      si,      // Data to device
   output logic      hold_n,  // Pause
   input  wire logic so,      // Data from device
   input  wire logic so_oe    // Device drives so
);
   logic so_line;
   logic last_so = 1'b0;
   // Released line shows the inverse level, never a stale bit
   assign so_line = so_oe ? so : ~last_so;
   always @(so or so_oe) if (so_oe) last_so = so;
   initial begin
      spi_sck = 1'b0; // Stands still between frames
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic xfer(input int n, input logic [39:0] d, input int hb, output logic [39:0] r);
      r = '0;
      cs_n = 1'b0;
      #30;
      for (int i = 0; i < n; i++) begin
         si = d[n - 1 - i];
         if (i == hb) begin
            #5 hold_n = 1'b0;
            repeat (2) begin
               si = ~si;
               #24 spi_sck = 1'b1;
               #24 spi_sck = 1'b0;
            end
            si = d[n - 1 - i];
            #10 hold_n = 1'b1;
         end
         #24 spi_sck = 1'b1;
         r = {r[38:0], so_line};
         #24 spi_sck = 1'b0;
      end
      #10 cs_n = 1'b1;
      si = ~si;
      #150;
   endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import secp_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b1;  // Starts high: link flops reset on a falling edge
   logic        wp_n = 1'b1;
   logic        spi_sck, cs_n, si, hold_n, so, so_oe, mem_wr, mem_id, hw_protect, id_locked, rd_id;
   logic [14:0] rd_addr, mem_addr;
   logic [7:0]  rd_data, mem_data, status;
   logic [39:0] r;
   logic [23:0] n_wr = '0;
   logic [23:0] last_wr;
   int          errors = 0;
   int          n_compared = 0;
   always #20 clk_sys = ~clk_sys;
   // Page and array give different bytes, so a wrong page select shows up
   assign rd_data = rd_addr[7:0] ^ (rd_id ? 8'h5A : 8'hA5);
   always @(negedge clk_sys) if (mem_wr === 1'b1) begin
      n_wr = n_wr + 24'h1;
      last_wr = {mem_id, mem_addr, mem_data};
   end
   secp_top #(.WRITE_CYC(100)) i_secp_top (.clk_sys, .rst_n, .spi_sck, .cs_n, .si, .hold_n, .wp_n, .so,
      .so_oe, .rd_addr, .rd_id, .rd_data, .mem_wr, .mem_addr, .mem_data, .mem_id, .status, .hw_protect,
      .id_locked);
   secp_master i_secp_master (.spi_sck, .cs_n, .si, .hold_n, .so, .so_oe);
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic clks(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic op(input int n, input logic [39:0] d, input int hb = -1);
      i_secp_master.xfer(n, d, hb, r);
      clks(4);
   endtask
   // A busy flag that never drops counts as a mismatch
   task automatic wait_idle;
      for (int k = 0; k < 300 && status[ST_BUSY_BIT] !== 1'b0; k++) clks(1);
      chk("busy clear", 1'b0, status[ST_BUSY_BIT]);
   endtask
   task automatic wr(input int n, input logic [39:0] d);
      op(8, 40'h06);
      op(n, d);
      wait_idle();
   endtask
   task automatic status_read_cmd(input logic [7:0] e, input logic [7:0] m = 8'hFF);
      op(16, 40'h0500);
      chk("status read", e, r[7:0] & m);
   endtask
   task automatic arr(input logic [14:0] a, input logic ok);
      logic [23:0] n0;
      n0 = n_wr;
      wr(32, {8'h02, 1'b0, a, 8'h3C});
      chk("array write count", n0 + ok, n_wr);
      if (ok) chk("array write", {1'b0, a, 8'h3C}, last_wr);
   endtask
   task automatic t_reset;
      @(posedge clk_sys) rst_n <= 1'b0;
      clks(10);
      rst_n <= 1'b1;
      clks(3);
      chk("status", 8'h00, status);
      chk("id locked", 1'b0, id_locked);
   endtask
   task automatic t_latch;
      for (int x = 0; x < 16; x += 8) begin
         op(8, 40'h06 | x);
         status_read_cmd(8'h02);
         op(8, 40'h04 | x);
         status_read_cmd(8'h00);
      end
      op(9, 40'h00C);
      status_read_cmd(8'h00);
      op(16, 40'h4006);
      status_read_cmd(8'h00);
   endtask
   task automatic t_stat;
      logic [23:0] n0;
      op(16, 40'h018C);
      status_read_cmd(8'h00);
      op(8, 40'h06);
      op(16, 40'h01FC);
      status_read_cmd(8'hFF);
      n0 = n_wr;
      op(32, 40'h0200_0055);
      chk("write while busy", n0, n_wr);
      wait_idle();
      status_read_cmd(8'h8C);
   endtask
   task automatic t_prot;
      arr(15'h0000, 1'b0);
      wr(16, 40'h0184);
      status_read_cmd(8'h84);
      @(posedge clk_sys) wp_n <= 1'b0;
      clks(5);
      chk("hw protect", 1'b1, hw_protect);
      wr(16, 40'h0104);
      status_read_cmd(8'h84, 8'hFC);
      arr(15'h5FFF, 1'b1);
      arr(15'h6000, 1'b0);
      @(posedge clk_sys) wp_n <= 1'b1;
      clks(5);
      wr(16, 40'h0108);
      status_read_cmd(8'h08);
      arr(15'h3FFF, 1'b1);
      arr(15'h4000, 1'b0);
      wr(16, 40'h0100);
      arr(15'h7FFF, 1'b1);
   endtask
   task automatic t_read;
      for (int h = -1; h < 30; h += 21) begin
         op(32, 40'h0301_2300, h);
         chk("array read", 8'h23 ^ 8'hA5, r[7:0]);
      end
   endtask
   task automatic t_id;
      logic [23:0] n0;
      wr(32, 40'h8200_055A);
      chk("page write", 24'h80055A, last_wr);
      op(32, 40'h8300_0500);
      chk("page read", 8'h05 ^ 8'h5A, r[7:0]);
      op(32, 40'h8204_0000);
      chk("lock status", 8'h00, r[7:0]);
      wr(32, 40'h8204_0002);
      chk("id locked", 1'b1, id_locked);
      op(32, 40'h8204_0000);
      chk("lock status", 8'h01, r[7:0]);
      n0 = n_wr;
      wr(32, 40'h8200_0566);
      chk("locked page write", n0, n_wr);
   endtask
   task automatic conclude;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      t_reset();
      t_latch();
      t_stat();
      t_prot();
      t_read();
      t_id();
      t_reset();
      status_read_cmd(8'h00);
      conclude();
   end
   initial begin
      #1000000;
      errors++;
      $display("mismatch watchdog expected done seen timeout");
      conclude();
   end
endmodule
